// ===== dv/tcisp_monitor.sv
// Concurrent checks on the bus wires and device events, link clock domain.
module tcisp_monitor (
  // Link clock and reset
  input wire logic link_clk_i,
  input wire logic reset_i,
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe_n,
  // Device events
  input wire logic reg_wr_o,
  input wire logic [7:0] reg_waddr_o,
  input wire logic soft_reset_o,
  input wire logic [6:0] slave_addr_o
);
  logic sda_q_r;
  logic seen_start_r;
  logic chain_r;
  logic [7:0] last_waddr_r;
  logic bus_start;
  logic bus_stop;

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (reset_i);

  assign bus_start = scl && sda_q_r && !sda;
  assign bus_stop = scl && !sda_q_r && sda;

  always_ff @(posedge link_clk_i) begin
    sda_q_r <= sda;
  end

  always_ff @(posedge link_clk_i) begin
    if (reset_i) seen_start_r <= 1'b0;
    else if (bus_start) seen_start_r <= 1'b1;
  end

  // A burst of committed writes begins afresh at every start or stop.
  always_ff @(posedge link_clk_i) begin
    if (reset_i || bus_start || bus_stop) chain_r <= 1'b0;
    else if (reg_wr_o) chain_r <= 1'b1;
  end

  always_ff @(posedge link_clk_i) begin
    if (reg_wr_o) last_waddr_r <= reg_waddr_o;
  end

  sequence s_held_low;
    !s_sda_oe_n [*8];
  endsequence
  sequence s_released;
    s_sda_oe_n [*8];
  endsequence

  property p_edge_low;
    $changed(s_sda_oe_n) |-> !scl;
  endproperty
  a_edge_low: assert property (p_edge_low)
    else $error("device changed data while clock high");
  property p_ack_hold;
    $rose(scl) && !s_sda_oe_n |-> s_held_low;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device let go of data during clock high");
  property p_quiet;
    !seen_start_r |-> s_sda_oe_n;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("device drove the bus before any start");
  property p_stop_idle;
    bus_stop |=> s_released;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("device drove the bus after a stop");
  property p_prefix;
    slave_addr_o[6:2] == 5'h16;
  endproperty
  a_prefix: assert property (p_prefix)
    else $error("slave address outside its range");
  property p_wr_pulse;
    reg_wr_o |-> !scl ##1 !reg_wr_o;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write commit not a single cycle with clock low");
  property p_wr_next;
    reg_wr_o && chain_r |-> reg_waddr_o == last_waddr_r + 8'h01;
  endproperty
  a_wr_next: assert property (p_wr_next)
    else $error("write address did not advance by one");
  property p_soft;
    soft_reset_o |-> !scl ##1 !soft_reset_o;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset pulse malformed");
endmodule : tcisp_monitor

// ===== dv/tcisp_tb.sv
// Self-checking bench joining the host end to the device end.
module tcisp_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic link_clk;
  logic reset;
  logic dev_reset_n;
  logic [1:0] addr_sel;
  logic cmd_valid;
  tcisp_pkg::tcisp_cmd_t cmd;
  logic [7:0] cmd_data;
  logic cmd_nack;
  logic cmd_ready;
  logic done;
  logic [7:0] rd_data;
  logic ack;
  logic [7:0] loc_addr;
  logic [7:0] loc_rdata;
  logic reg_wr;
  logic [7:0] reg_waddr;
  logic [7:0] reg_wdata;
  logic soft_reset;
  logic [6:0] slave_addr;
  logic [15:0] wr_q[$];
  int soft_cnt;
  int mismatches;
  int num_checks;

  tcisp_if bus_if ();

  tcisp_host u_tcisp_host (.clk_i(clk), .reset_i(reset), .bus(bus_if),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_data_i(cmd_data),
    .cmd_nack_i(cmd_nack), .cmd_ready_o(cmd_ready), .done_o(done),
    .rd_data_o(rd_data), .ack_o(ack));
  tcisp_device u_tcisp_device (.link_clk_i(link_clk), .reset_i(reset),
    .dev_reset_n_i(dev_reset_n), .addr_sel_i(addr_sel), .bus(bus_if),
    .loc_wr_i(1'b0), .loc_addr_i(loc_addr), .loc_data_i(8'h00),
    .loc_rdata_o(loc_rdata), .reg_wr_o(reg_wr), .reg_waddr_o(reg_waddr),
    .reg_wdata_o(reg_wdata), .soft_reset_o(soft_reset),
    .slave_addr_o(slave_addr));
  tcisp_monitor u_tcisp_monitor (.link_clk_i(link_clk), .reset_i(reset),
    .scl(bus_if.scl), .sda(bus_if.sda), .s_sda_oe_n(bus_if.s_sda_oe_n),
    .reg_wr_o(reg_wr), .reg_waddr_o(reg_waddr),
    .soft_reset_o(soft_reset), .slave_addr_o(slave_addr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // Pulses are taken at the falling edge so the design's updates have landed.
  always @(negedge link_clk) begin
    if (reg_wr === 1'b1) wr_q.push_back({reg_waddr, reg_wdata});
    if (soft_reset === 1'b1) soft_cnt++;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic op(input tcisp_pkg::tcisp_cmd_t c, input logic [7:0] d,
                    input logic nk);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_data <= d;
    cmd_nack <= nk;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000) begin
      mismatches++;
      $display("ERROR t=%0t host command never finished", $time);
    end
  endtask : op

  task automatic st();
    op(tcisp_pkg::CMD_START, 8'h00, 1'b0);
  endtask : st
  task automatic sp();
    op(tcisp_pkg::CMD_STOP, 8'h00, 1'b0);
  endtask : sp
  task automatic wb(input logic [7:0] d, input logic exp_ack);
    op(tcisp_pkg::CMD_WRITE, d, 1'b0);
    check({7'h00, ack}, {7'h00, exp_ack}, "ninth bit");
  endtask : wb
  task automatic rb(input logic nk, input logic [7:0] exp);
    op(tcisp_pkg::CMD_READ, 8'h00, nk);
    check(rd_data, exp, "read data");
  endtask : rb
  task automatic exp_wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] e;
    e = 'x;
    if (wr_q.size() > 0) e = wr_q.pop_front();
    check(e[15:8], a, "write address");
    check(e[7:0], d, "write data");
  endtask : exp_wr

  // Burst write across the top of the space, then a local read-back.
  task automatic sc_write();
    check({1'b0, slave_addr}, 8'h5A, "address");
    st();
    wb(8'hB4, 1'b1);
    wb(8'hFE, 1'b1);
    wb(8'hA1, 1'b1);
    wb(8'hB2, 1'b1);
    wb(8'hC3, 1'b1);
    sp();
    exp_wr(8'hFE, 8'hA1);
    exp_wr(8'hFF, 8'hB2);
    exp_wr(8'h00, 8'hC3);
    @(posedge clk);
    loc_addr <= 8'hFF;
    repeat (4) @(posedge link_clk);
    @(negedge clk);
    check(loc_rdata, 8'hB2, "stored byte");
  endtask : sc_write

  task automatic sc_read();
    st();
    wb(8'hB4, 1'b1);
    wb(8'hFF, 1'b1);
    st();
    wb(8'hB5, 1'b1);
    rb(1'b0, 8'hB2);
    rb(1'b1, 8'hC3);
    sp();
  endtask : sc_read

  task automatic sc_miss();
    st();
    wb(8'hB6, 1'b0);
    wb(8'h55, 1'b0);
    sp();
    check(8'(wr_q.size()), 8'h00, "stray write");
  endtask : sc_miss

  // The reset pin must bring the counter back to the bottom of the space.
  task automatic sc_rst();
    @(posedge clk);
    dev_reset_n <= 1'b0;
    repeat (10) @(posedge link_clk);
    @(posedge clk);
    dev_reset_n <= 1'b1;
    repeat (60) @(posedge clk);
    check({1'b0, slave_addr}, 8'h5B, "address after reset");
    st();
    wb(8'hB7, 1'b1);
    rb(1'b1, 8'hC3);
    sp();
  endtask : sc_rst

  task automatic sc_gcall();
    logic [1:0] sels [3] = '{2'b01, 2'b11, 2'b11};
    logic [7:0] cmds [3] = '{8'h04, 8'h07, 8'h06};
    logic [7:0] addrs [3] = '{8'h59, 8'h59, 8'h5B};
    logic [7:0] softs [3] = '{8'h00, 8'h00, 8'h01};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      addr_sel <= sels[i];
      st();
      wb(8'h00, 1'b1);
      wb(cmds[i], 1'b1);
      sp();
      check({1'b0, slave_addr}, addrs[i], "latched address");
      check(8'(soft_cnt), softs[i], "soft reset");
    end
    check(8'(wr_q.size()), 8'h00, "stray write");
    st();
    wb(8'hB7, 1'b1);
    rb(1'b1, 8'hC3);
    sp();
  endtask : sc_gcall

  task automatic sc_ten();
    st();
    wb(8'hF0, 1'b1);
    wb(8'h5B, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h3C, 1'b1);
    sp();
    exp_wr(8'h10, 8'h3C);
  endtask : sc_ten

  initial begin
    reset = 1'b1;
    dev_reset_n = 1'b0;
    addr_sel = 2'b10;
    cmd_valid = 1'b0;
    cmd = tcisp_pkg::CMD_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    loc_addr = 8'h00;
    soft_cnt = 0;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    dev_reset_n <= 1'b1;
    repeat (60) @(posedge clk);
    sc_write();
    sc_read();
    sc_miss();
    sc_gcall();
    sc_ten();
    sc_rst();
    end_sim();
  end

  // The full run needs about 660 us, so this only trips on a hang.
  initial begin
    #800us;
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule : tcisp_tb

// ===== hdl/tcisp_device.sv
// Device end of the touch controller serial slave port with its registers.

// Summary of operation
// - Address 0x58 to 0x5B from two select pins.
// - Works at standard and fast bus speeds.
// - Accepts seven-bit and ten-bit device addressing.
// - No high-speed, hardware general call or CBUS.
// - Start: data falls with clock high.
// - Stop: data rises with clock high; idle.
// - Transmitter releases data; receiver acks ninth bit.
// - Data sampled on rising clock, changes low.
// - Direction bit one reads, zero writes.
// - Ack matching address; otherwise stay off bus.
// - Eight-bit register address, 256 byte registers.
// - Master reads via address write, repeated start.
// - Reads continue sequentially, counter wraps to zero.
// - Master nack ends read; device goes idle.
// - Writes store acked bytes, counter advances, wraps.
// - General call acknowledged, next byte is command.
// - Command 0x06 soft resets and latches address.
// - Command 0x04 latches address without reset.
// - Other general-call command bytes are ignored.
// - Master waits about 2 us after command.
// - Port works in every power state.
// - Low reset pin clears port and counter.
module tcisp_device (
  // Link clock and resets
  input wire logic link_clk_i,
  input wire logic reset_i,
  input wire logic dev_reset_n_i,
  // Address select pins
  input wire logic [1:0] addr_sel_i,
  // Serial bus
  tcisp_if.slave bus,
  // Local register access on the link clock
  input wire logic loc_wr_i,
  input wire logic [7:0] loc_addr_i,
  input wire logic [7:0] loc_data_i,
  output logic [7:0] loc_rdata_o,
  // Events towards the register space
  output logic reg_wr_o,
  output logic [7:0] reg_waddr_o,
  output logic [7:0] reg_wdata_o,
  output logic soft_reset_o,
  output logic [6:0] slave_addr_o
);

  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_ADDR10,
    D_REG,
    D_WDATA,
    D_GCMD,
    D_RDATA,
    D_IGNORE
  } tcisp_dstate_t;

  tcisp_dstate_t state_r;
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic [2:0] rstn_sync_r;
  logic [2:0] sel0_sync_r;
  logic [2:0] sel1_sync_r;
  logic scl_f_r;
  logic sda_f_r;
  logic rstn_f_r;
  logic [1:0] sel_f_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic [7:0] mem_r [256];
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic [1:0] sel_lat_r;
  logic [1:0] settle_r;
  logic ack_ph_r;
  logic acked_r;
  logic mack_r;
  logic ten_r;
  logic sda_oe_n_r;
  logic drive_lo_r;
  logic dev_rst;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic [6:0] own7;
  logic hit7;
  logic gcall;
  logic ten_hit;
  logic give_ack;
  logic [7:0] rd_byte;

  // The port is never gated by the power state.
  assign dev_rst = reset_i || !rstn_f_r;
  assign bus.s_sda_o = drive_lo_r;
  assign bus.s_sda_oe_n = sda_oe_n_r;
  assign slave_addr_o = {tcisp_pkg::ADDR_PREFIX, sel_lat_r};
  assign rd_byte = mem_r[ptr_r];

  // Oversampling on the link clock keeps edges well inside a fast-mode
  // bit; the three-stage filter costs four link cycles of latency.
  always_ff @(posedge link_clk_i) begin
    if (reset_i) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      rstn_sync_r <= 3'h0;
      sel0_sync_r <= 3'h0;
      sel1_sync_r <= 3'h0;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      rstn_f_r <= 1'b0;
      sel_f_r <= 2'h0;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], bus.scl};
      sda_sync_r <= {sda_sync_r[1:0], bus.sda};
      rstn_sync_r <= {rstn_sync_r[1:0], dev_reset_n_i};
      sel0_sync_r <= {sel0_sync_r[1:0], addr_sel_i[0]};
      sel1_sync_r <= {sel1_sync_r[1:0], addr_sel_i[1]};
      scl_f_r <= tcisp_pkg::tcisp_agree(scl_sync_r[1], scl_sync_r[2], scl_f_r);
      sda_f_r <= tcisp_pkg::tcisp_agree(sda_sync_r[1], sda_sync_r[2], sda_f_r);
      rstn_f_r <= tcisp_pkg::tcisp_agree(rstn_sync_r[1], rstn_sync_r[2],
                                         rstn_f_r);
      sel_f_r[0] <= tcisp_pkg::tcisp_agree(sel0_sync_r[1], sel0_sync_r[2],
                                           sel_f_r[0]);
      sel_f_r[1] <= tcisp_pkg::tcisp_agree(sel1_sync_r[1], sel1_sync_r[2],
                                           sel_f_r[1]);
      scl_prev_r <= scl_f_r;
      sda_prev_r <= sda_f_r;
    end
  end

  assign start_det = scl_f_r && scl_prev_r && sda_prev_r && !sda_f_r;
  assign stop_det = scl_f_r && scl_prev_r && !sda_prev_r && sda_f_r;
  assign scl_rise = scl_f_r && !scl_prev_r;
  assign scl_fall = !scl_f_r && scl_prev_r;

  // Acknowledge decision for the byte just received.
  always_comb begin
    own7 = {tcisp_pkg::ADDR_PREFIX, sel_lat_r};
    hit7 = (shift_r[7:1] == own7);
    gcall = (shift_r == tcisp_pkg::GC_ADDR);
    // Only the general-call and ten-bit prefix codes are decoded among the
    // reserved codes, so high-speed and CBUS codes are never acknowledged.
    ten_hit = (shift_r[7:3] == tcisp_pkg::TEN_PREFIX) &&
              (shift_r[2:1] == tcisp_pkg::TEN_ADDR_HI) &&
              (!shift_r[0] || ten_r);
    case (state_r)
      D_ADDR: give_ack = hit7 || gcall || ten_hit;
      D_ADDR10: give_ack = (shift_r == {1'b0, own7});
      D_REG, D_WDATA, D_GCMD: give_ack = 1'b1;
      default: give_ack = 1'b0;
    endcase
  end

  always_ff @(posedge link_clk_i) begin
    drive_lo_r <= 1'b0;
    if (dev_rst) begin
      state_r <= D_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= tcisp_pkg::PTR_RESET;
      sel_lat_r <= 2'h0;
      settle_r <= tcisp_pkg::ADDR_SETTLE;
      ack_ph_r <= 1'b0;
      acked_r <= 1'b0;
      mack_r <= 1'b0;
      ten_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      reg_wr_o <= 1'b0;
      reg_waddr_o <= 8'h00;
      reg_wdata_o <= 8'h00;
      soft_reset_o <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      soft_reset_o <= 1'b0;
      // Pins are caught once the filter has settled after reset release.
      if (settle_r != 2'h0) begin
        settle_r <= settle_r - 2'h1;
        if (settle_r == 2'h1) begin
          sel_lat_r <= sel_f_r;
        end
      end
      if (start_det) begin
        // A start drops any partial byte and rearms address reception.
        state_r <= D_ADDR;
        cnt_r <= 4'h0;
        ack_ph_r <= 1'b0;
        sda_oe_n_r <= 1'b1;
      end else if (stop_det) begin
        state_r <= D_IDLE;
        cnt_r <= 4'h0;
        ack_ph_r <= 1'b0;
        ten_r <= 1'b0;
        sda_oe_n_r <= 1'b1;
      end else if (state_r != D_IDLE && state_r != D_IGNORE) begin
        if (scl_rise) begin
          if (!ack_ph_r) begin
            shift_r <= {shift_r[6:0], sda_f_r};
            cnt_r <= cnt_r + 4'h1;
          end else begin
            mack_r <= !sda_f_r;
          end
        end else if (scl_fall && !ack_ph_r &&
                     cnt_r == tcisp_pkg::DATA_BITS) begin
          ack_ph_r <= 1'b1;
          if (state_r == D_RDATA) begin
            sda_oe_n_r <= 1'b1;
          end else begin
            acked_r <= give_ack;
            sda_oe_n_r <= !give_ack;
          end
        end else if (scl_fall && !ack_ph_r && state_r == D_RDATA) begin
          sda_oe_n_r <= tx_r[3'(4'h7 - cnt_r)];
        end else if (scl_fall && ack_ph_r) begin
          ack_ph_r <= 1'b0;
          cnt_r <= 4'h0;
          sda_oe_n_r <= 1'b1;
          case (state_r)
            D_ADDR: begin
              if (!acked_r) begin
                state_r <= D_IGNORE;
              end else if (gcall) begin
                state_r <= D_GCMD;
              end else if (ten_hit && !shift_r[0]) begin
                state_r <= D_ADDR10;
              end else if (shift_r[0]) begin
                state_r <= D_RDATA;
                tx_r <= rd_byte;
                sda_oe_n_r <= rd_byte[7];
                ptr_r <= ptr_r + 8'h01;
              end else begin
                state_r <= D_REG;
                ten_r <= 1'b0;
              end
            end
            D_ADDR10: begin
              state_r <= acked_r ? D_REG : D_IGNORE;
              ten_r <= acked_r;
            end
            D_REG: begin
              ptr_r <= shift_r;
              state_r <= D_WDATA;
            end
            D_WDATA: begin
              reg_wr_o <= 1'b1;
              reg_waddr_o <= ptr_r;
              reg_wdata_o <= shift_r;
              ptr_r <= ptr_r + 8'h01;
            end
            D_GCMD: begin
              state_r <= D_IGNORE;
              if (shift_r == tcisp_pkg::GC_CMD_SRST) begin
                soft_reset_o <= 1'b1;
                ptr_r <= tcisp_pkg::PTR_RESET;
                ten_r <= 1'b0;
                sel_lat_r <= sel_f_r;
              end else if (shift_r == tcisp_pkg::GC_CMD_LATCH) begin
                sel_lat_r <= sel_f_r;
              end
              // Any other command byte has no effect.
            end
            D_RDATA: begin
              if (mack_r) begin
                tx_r <= rd_byte;
                sda_oe_n_r <= rd_byte[7];
                ptr_r <= ptr_r + 8'h01;
              end else begin
                state_r <= D_IDLE;
              end
            end
            default: state_r <= D_IGNORE;
          endcase
        end
      end
    end
  end

  // Register space; a bus write in the same cycle wins over a local write.
  always_ff @(posedge link_clk_i) begin
    if (reg_wr_o) begin
      mem_r[reg_waddr_o] <= reg_wdata_o;
    end else if (loc_wr_i) begin
      mem_r[loc_addr_i] <= loc_data_i;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (dev_rst) begin
      loc_rdata_o <= 8'h00;
    end else begin
      loc_rdata_o <= mem_r[loc_addr_i];
    end
  end

endmodule : tcisp_device

// ===== hdl/tcisp_host.sv
// Bus master end that generates the serial clock and issues byte commands.
module tcisp_host (
  // System clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Serial bus
  tcisp_if.master bus,
  // Command port
  input wire logic cmd_valid_i,
  input wire tcisp_pkg::tcisp_cmd_t cmd_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_nack_i,
  output logic cmd_ready_o,
  // Results
  output logic done_o,
  output logic [7:0] rd_data_o,
  output logic ack_o
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_BIT,
    H_STOP,
    H_GAP
  } tcisp_hstate_t;

  tcisp_hstate_t state_r;
  logic [2:0] sda_sync_r;
  logic sda_f_r;
  logic [6:0] div_r;
  logic [7:0] gap_r;
  logic [1:0] phase_r;
  logic [3:0] bit_r;
  logic [8:0] tx_r;
  logic [8:0] rx_r;
  logic scl_oe_n_r;
  logic sda_oe_n_r;
  logic drive_lo_r;
  logic tick;

  assign tick = (state_r != H_IDLE) && (state_r != H_GAP) &&
                (div_r == tcisp_pkg::QUARTER_LAST);
  assign bus.m_scl_o = drive_lo_r;
  assign bus.m_sda_o = drive_lo_r;
  assign bus.m_scl_oe_n = scl_oe_n_r;
  assign bus.m_sda_oe_n = sda_oe_n_r;

  // The sampled data line crosses from the bus into the system clock.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sda_sync_r <= 3'h7;
      sda_f_r <= 1'b1;
    end else begin
      sda_sync_r <= {sda_sync_r[1:0], bus.sda};
      sda_f_r <= tcisp_pkg::tcisp_agree(sda_sync_r[1], sda_sync_r[2],
                                        sda_f_r);
    end
  end

  // Quarter-bit divider; the bus clock is derived from it.
  always_ff @(posedge clk_i) begin
    if (reset_i || state_r == H_IDLE || tick) begin
      div_r <= 7'h00;
    end else begin
      div_r <= div_r + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= H_IDLE;
      phase_r <= 2'h0;
      bit_r <= 4'h0;
      tx_r <= 9'h1ff;
      rx_r <= 9'h000;
      gap_r <= 8'h00;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      drive_lo_r <= 1'b0;
      cmd_ready_o <= 1'b1;
      done_o <= 1'b0;
      rd_data_o <= 8'h00;
      ack_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (tick) begin
        phase_r <= phase_r + 2'h1;
      end
      case (state_r)
        H_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            phase_r <= 2'h0;
            bit_r <= 4'h0;
            case (cmd_i)
              tcisp_pkg::CMD_START: state_r <= H_START;
              tcisp_pkg::CMD_WRITE: begin
                tx_r <= {cmd_data_i, 1'b1};
                state_r <= H_BIT;
              end
              tcisp_pkg::CMD_READ: begin
                tx_r <= {8'hff, cmd_nack_i};
                state_r <= H_BIT;
              end
              default: state_r <= H_STOP;
            endcase
          end
        end
        H_START: begin
          // From a low clock this is a repeated start.
          if (tick) begin
            case (phase_r)
              2'h0: sda_oe_n_r <= 1'b1;
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: sda_oe_n_r <= 1'b0;
              default: begin
                scl_oe_n_r <= 1'b0;
                state_r <= H_IDLE;
                cmd_ready_o <= 1'b1;
                done_o <= 1'b1;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            case (phase_r)
              2'h0: sda_oe_n_r <= tx_r[8];
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: rx_r <= {rx_r[7:0], sda_f_r};
              default: begin
                scl_oe_n_r <= 1'b0;
                tx_r <= {tx_r[7:0], 1'b1};
                bit_r <= bit_r + 4'h1;
                if (bit_r == tcisp_pkg::HOST_LAST_BIT) begin
                  state_r <= H_IDLE;
                  cmd_ready_o <= 1'b1;
                  done_o <= 1'b1;
                  rd_data_o <= rx_r[8:1];
                  ack_o <= !rx_r[0];
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            case (phase_r)
              2'h0: sda_oe_n_r <= 1'b0;
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: sda_oe_n_r <= 1'b1;
              default: begin
                gap_r <= 8'h00;
                state_r <= H_GAP;
              end
            endcase
          end
        end
        default: begin
          // Bus free time after every stop covers the general-call wait.
          gap_r <= gap_r + 8'h01;
          if (gap_r == tcisp_pkg::GAP_LAST) begin
            state_r <= H_IDLE;
            cmd_ready_o <= 1'b1;
            done_o <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule : tcisp_host

// ===== hdl/tcisp_if.sv
// Two-wire bus between the host end and the device end, with pull-ups.
interface tcisp_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // Open drain: a line is low when any enabled driver pulls it low.
  assign scl = (!m_scl_oe_n && !m_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o)) ?
               1'b0 : 1'b1;

  modport master (
    output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n,
    input scl, sda
  );
  modport slave (
    output s_sda_o, s_sda_oe_n,
    input scl, sda
  );
endinterface : tcisp_if

// ===== hdl/tcisp_pkg.sv
// Shared constants and types for the touch controller serial slave port.
package tcisp_pkg;

  // Rounds a least time up to whole clock cycles.
  function automatic int tcisp_cyc_up(input int time_ns, input int per_ns);
    return (time_ns + per_ns - 1) / per_ns;
  endfunction : tcisp_cyc_up

  // Takes a new level once the second and third sampling stages agree.
  function automatic logic tcisp_agree(input logic s2, input logic s3,
                                       input logic old);
    return (s2 == s3) ? s3 : old;
  endfunction : tcisp_agree

  // Host timing, on the 125 MHz system clock.
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_QUARTER_NS = 625;
  localparam int QUARTER_CYC = tcisp_cyc_up(BIT_QUARTER_NS, CLK_PERIOD_NS);
  localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);
  localparam int BUS_GAP_NS = 2000;
  localparam int BUS_GAP_CYC = tcisp_cyc_up(BUS_GAP_NS, CLK_PERIOD_NS);
  localparam logic [7:0] GAP_LAST = 8'(BUS_GAP_CYC - 1);

  // Addressing.
  localparam logic [4:0] ADDR_PREFIX = 5'h16;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_CMD_SRST = 8'h06;
  localparam logic [7:0] GC_CMD_LATCH = 8'h04;
  localparam logic [4:0] TEN_PREFIX = 5'h1e;
  localparam logic [1:0] TEN_ADDR_HI = 2'h0;

  // Byte framing and reset values.
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] HOST_LAST_BIT = 4'h8;
  localparam logic [1:0] ADDR_SETTLE = 2'h3;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Byte-level commands of the host end.
  typedef enum logic [1:0] {
    CMD_START,
    CMD_WRITE,
    CMD_READ,
    CMD_STOP
  } tcisp_cmd_t;

endpackage : tcisp_pkg
